// File: core/tco_pkg.sv
// shared constants and types for the four-channel capture / one-shot timer
package tco_pkg;

  // unit shape
  localparam int NUM_CH    = 4;           // channels 0 to 3
  localparam int CNT_W     = 16;          // counter and data width

  // counter load values and count step
  localparam logic [15:0] CNT_ZERO  = 16'h0000; // load on capture start
  localparam logic [15:0] CNT_ONES  = 16'hffff; // park after one-count end
  localparam logic [15:0] CNT_ONE   = 16'h0001; // count step

  // reset values
  localparam logic [15:0] RST_CNT   = 16'h0000; // counter after reset
  localparam logic [15:0] RST_DATA  = 16'h0000; // data register after reset
  localparam logic        RST_OUT   = 1'h0;     // output level after reset

  // count clock prescaler default (operating clock cycles per count clock)
  localparam int DEF_COUNT_DIV = 4;

  // counter modes of a channel
  typedef enum logic [1:0] {
    MODE_CAPTURE,        // input pulse interval capture
    MODE_ONE_COUNT,      // retriggerable one-shot down count
    MODE_CAP_ONE_COUNT   // high-level width measurement
  } tco_mode_t;

  // per-channel configuration carried as one packed word
  typedef struct packed {
    tco_mode_t mode;                    // counter mode
    logic      start_interrupt_select;  // interrupt at count start, capture mode only
    logic      filter_enable;           // input noise filter on
    logic      output_enable_bit;       // interrupts drive the output
    logic      output_mode_select;      // 0 toggle, 1 set/reset
    logic      output_polarity_bit;     // swaps set and reset roles
  } tco_cfg_t;

  // per-channel status carried as one packed word
  typedef struct packed {
    logic [15:0] channel_counter;       // live counter
    logic [15:0] reload_capture_value;  // data register
  } tco_stat_t;

endpackage

// File: core/tco_timer.sv
// four-channel timer: capture, one-count, width capture and output circuit
`timescale 1ns/100ps

module tco_timer
  import tco_pkg::*;
#(
  parameter int COUNT_DIV = DEF_COUNT_DIV  // operating clocks per count clock
) (
  input  wire logic                 CLK_I,                 // 100 MHz clock
  input  wire logic                 RESET_I,               // sync, high
  input  wire logic [NUM_CH-1:0]    TIMER_INPUT_PIN_I,     // async pins
  input  wire tco_cfg_t [NUM_CH-1:0] CFG_I,                // channel setup
  input  wire logic [NUM_CH-1:0]    CHANNEL_START_TRIGGER_I, // start pulse
  input  wire logic [NUM_CH-1:0]    CHANNEL_STOP_I,        // stop pulse
  input  wire logic [NUM_CH-1:0]    RELOAD_WR_I,           // data write
  input  wire logic [15:0]          RELOAD_WDATA_I,        // data to write
  input  wire logic                 OUTPUT_LEVEL_WR_I,     // level write
  input  wire logic [NUM_CH-1:0]    OUTPUT_LEVEL_WDATA_I,  // levels
  output logic [NUM_CH-1:0]         CHANNEL_ENABLED_FLAG_O, // running flags
  output logic [NUM_CH-1:0]         CHANNEL_INTERRUPT_O,   // 1-cycle pulse
  output logic [NUM_CH-1:0]         START_DETECT_O,        // 1-cycle pulse
  output tco_stat_t [NUM_CH-1:0]    STATUS_O,              // counter, data
  output logic [NUM_CH-1:0]         TIMER_OUTPUT_PIN_O,    // output pins
  output logic [NUM_CH-1:0]         OUTPUT_LEVEL_GROUP_O   // readback
);

  // prescaler width wide enough for any sensible divide
  localparam int DIV_W = (COUNT_DIV > 1) ? $clog2(COUNT_DIV) : 1;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(COUNT_DIV - 1);

  logic [DIV_W-1:0] div_q;   // prescaler count
  logic [DIV_W-1:0] div_d;   // prescaler next value
  logic             tick;    // count clock, one cycle wide

  // shared count clock: every channel sees the same tick
  assign tick  = (div_q == DIV_LAST);
  assign div_d = tick ? '0 : DIV_W'(div_q + 1'b1);

  // prescaler register
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      div_q <= '0;
    end else begin
      div_q <= div_d;
    end
  end

  // channel interrupts gathered so the output circuit can cross channels
  logic [NUM_CH-1:0] irq_w;     // per-channel interrupt pulses
  logic [NUM_CH-1:0] out_w;     // per-channel output levels

  assign OUTPUT_LEVEL_GROUP_O = out_w;
  assign TIMER_OUTPUT_PIN_O   = out_w;
  assign CHANNEL_INTERRUPT_O  = irq_w;

  genvar i;
  generate
    for (i = 0; i < NUM_CH; i++) begin : g_ch
      // master feeding this channel in slave mode; channel 0 has none
      localparam int MI    = (i == 3) ? 2 : 0;
      localparam bit HAS_M = (i != 0);

      logic        sync1_q;     // first synchroniser stage
      logic        sync2_q;     // second synchroniser stage
      logic        filt_prev_q; // previous synced sample
      logic        filt_q;      // filtered level
      logic        lvl_prev_q;  // level seen last cycle
      logic        lvl;         // level after optional filter
      logic        rise;        // valid rising edge
      logic        fall;        // valid falling edge
      logic        en_q;        // channel enabled flag
      logic        run_q;       // counting, start trigger seen
      logic        irq_q;       // interrupt pulse
      logic        std_q;       // start detect pulse
      logic [15:0] cnt_q;       // channel counter
      logic [15:0] cnt_d;       // channel counter next
      logic [15:0] data_q;      // reload / capture value
      logic [15:0] data_d;      // reload / capture next
      logic        en_d;        // enabled next
      logic        run_d;       // running next
      logic        irq_d;       // interrupt next
      logic        std_d;       // start detect next
      logic        out_q;       // output level
      logic        out_d;       // output level next
      logic        m_irq;       // master interrupt seen by this channel
      logic        set_ev;      // output set event
      logic        rst_ev;      // output reset event
      tco_cfg_t    cfg;         // this channel's setup

      assign cfg = CFG_I[i];

      // two flops before anything reads the pin; stage one feeds stage two
      always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
          sync1_q <= 1'b0;
          sync2_q <= 1'b0;
        end else begin
          sync1_q <= TIMER_INPUT_PIN_I[i];
          sync2_q <= sync1_q;
        end
      end

      always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
          filt_prev_q <= 1'b0;
          filt_q      <= 1'b0;
        end else begin
          filt_prev_q <= sync2_q;
          if (sync2_q == filt_prev_q) begin
            filt_q <= sync2_q;
          end
        end
      end

      // filter path is two cycles later
      assign lvl  = cfg.filter_enable ? filt_q : sync2_q;
      assign rise = lvl & ~lvl_prev_q;
      assign fall = ~lvl & lvl_prev_q;

      // edge detector memory
      always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
          lvl_prev_q <= 1'b0;
        end else begin
          lvl_prev_q <= lvl;
        end
      end

      // counter control; output settings never enter here
      // counting ignores output setup
      always_comb begin
        cnt_d  = cnt_q;
        data_d = data_q;
        en_d   = en_q;
        run_d  = run_q;
        irq_d  = 1'b0;
        std_d  = 1'b0;
        // software data write; a capture in the same cycle wins below
        if (RELOAD_WR_I[i]) begin
          data_d = RELOAD_WDATA_I;
        end
        if (CHANNEL_STOP_I[i]) begin
          // stop freezes the counter where it stands
          en_d  = 1'b0;
          run_d = 1'b0;
        end else if (CHANNEL_START_TRIGGER_I[i] && !en_q) begin
          en_d  = 1'b1;
          run_d = 1'b0;
        end else if (en_q) begin
          case (cfg.mode)
            MODE_CAPTURE: begin
              if (!run_q) begin
                if (tick) begin
                  cnt_d = CNT_ZERO;
                  run_d = 1'b1;
                  std_d = 1'b1;
                  irq_d = cfg.start_interrupt_select;
                end
              end else if (rise) begin
                data_d = cnt_q;
                cnt_d  = CNT_ZERO;
                irq_d  = 1'b1;
              end else if (tick) begin
                cnt_d = 16'(cnt_q + CNT_ONE);
              end
            end
            MODE_ONE_COUNT: begin
              if (rise) begin
                // edge loads data value
                // retrigger while running reloads as well
                cnt_d = data_q;
                run_d = 1'b1;
                std_d = 1'b1;
              end else if (run_q && tick) begin
                if (cnt_q == CNT_ZERO) begin
                  cnt_d = CNT_ONES;
                  run_d = 1'b0;
                  irq_d = 1'b1;
                end else begin
                  cnt_d = 16'(cnt_q - CNT_ONE);
                end
              end
            end
            MODE_CAP_ONE_COUNT: begin
              if (rise) begin
                cnt_d = CNT_ZERO;
                run_d = 1'b1;
                std_d = 1'b1;
              end else if (run_q && fall) begin
                data_d = cnt_q;
                run_d  = 1'b0;
                irq_d  = 1'b1;
              end else if (run_q && tick) begin
                cnt_d = 16'(cnt_q + CNT_ONE);
              end
            end
            default: begin
              run_d = 1'b0;
            end
          endcase
        end
      end

      // channel state registers
      always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
          cnt_q  <= RST_CNT;
          data_q <= RST_DATA;
          en_q   <= 1'b0;
          run_q  <= 1'b0;
          irq_q  <= 1'b0;
          std_q  <= 1'b0;
        end else begin
          cnt_q  <= cnt_d;
          data_q <= data_d;
          en_q   <= en_d;
          run_q  <= run_d;
          irq_q  <= irq_d;
          std_q  <= std_d;
        end
      end

      // master interrupt source for slave output mode
      if (HAS_M) begin : g_m
        assign m_irq = irq_w[MI];
      end else begin : g_nm
        assign m_irq = 1'b0;
      end

      assign set_ev = cfg.output_polarity_bit ? irq_q : m_irq;
      assign rst_ev = cfg.output_polarity_bit ? m_irq : irq_q;

      // output circuit; interrupts act one cycle after the pulse
      always_comb begin
        out_d = out_q;
        if (!cfg.output_enable_bit) begin
          if (OUTPUT_LEVEL_WR_I) begin
            out_d = OUTPUT_LEVEL_WDATA_I[i];
          end
        end else if (!cfg.output_mode_select) begin
          if (irq_q) begin
            out_d = ~out_q;
          end
        end else begin
          if (rst_ev) begin
            out_d = 1'b0;
          end else if (set_ev) begin
            out_d = 1'b1;
          end
        end
      end

      // output level register
      always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
          out_q <= RST_OUT;
        end else begin
          out_q <= out_d;
        end
      end

      // status to the ports; all from flops
      assign irq_w[i]                       = irq_q;
      assign out_w[i]                       = out_q;
      assign START_DETECT_O[i]              = std_q;
      assign CHANNEL_ENABLED_FLAG_O[i]      = en_q;
      assign STATUS_O[i].channel_counter      = cnt_q;
      assign STATUS_O[i].reload_capture_value = data_q;
    end
  endgenerate

endmodule

// File: tb/tco_signal_source.sv
// far-side model: timer input signal source feeding the pins
`timescale 1ns/100ps
module tco_signal_source (
  input  wire logic [3:0] level_i,  // levels the bench asks for
  output logic      [3:0] pin_o     // levels seen at the timer pins
);
  // pins move a fraction of a cycle after the request, never on an edge,
  // so the synchroniser sees a truly asynchronous change; one process
  // owns the pins so they start low and have a single driver
  initial begin
    pin_o = 4'h0;
    forever begin
      @(level_i);
      pin_o <= #3.3 level_i;
    end
  end
endmodule

// File: tb/tco_timer_properties.sv
// concurrent checks on the timer ports, bound into the timer
`timescale 1ns/100ps
module tco_timer_properties
  import tco_pkg::*;
(
  input wire logic                   CLK_I,
  input wire logic                   RESET_I,
  input wire tco_cfg_t [NUM_CH-1:0]  CFG_I,
  input wire logic [NUM_CH-1:0]      CHANNEL_START_TRIGGER_I,
  input wire logic [NUM_CH-1:0]      CHANNEL_STOP_I,
  input wire logic                   OUTPUT_LEVEL_WR_I,
  input wire logic [NUM_CH-1:0]      OUTPUT_LEVEL_WDATA_I,
  input wire logic [NUM_CH-1:0]      CHANNEL_ENABLED_FLAG_O,
  input wire logic [NUM_CH-1:0]      CHANNEL_INTERRUPT_O,
  input wire logic [NUM_CH-1:0]      START_DETECT_O,
  input wire tco_stat_t [NUM_CH-1:0] STATUS_O,
  input wire logic [NUM_CH-1:0]      TIMER_OUTPUT_PIN_O,
  input wire logic [NUM_CH-1:0]      OUTPUT_LEVEL_GROUP_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RESET_I);
  // channel 0 is the master, channel 1 its follower
  wire tco_cfg_t    c0  = CFG_I[0];
  wire tco_cfg_t    c1  = CFG_I[1];
  wire logic [15:0] cnt = STATUS_O[0].channel_counter;
  wire logic [15:0] dat = STATUS_O[0].reload_capture_value;
  wire logic [1:0]  irq = CHANNEL_INTERRUPT_O[1:0];
  wire logic [1:0]  pin = TIMER_OUTPUT_PIN_O[1:0];

  start_sets_flag_a: assert property (
    CHANNEL_START_TRIGGER_I[0] && !CHANNEL_STOP_I[0]
    |=> CHANNEL_ENABLED_FLAG_O[0]) else $error("flag not set");
  capture_start_a: assert property (
    START_DETECT_O[0] && c0.mode == MODE_CAPTURE |-> cnt == CNT_ZERO
    && (irq[0] || !c0.start_interrupt_select)) else $error("bad start");
  capture_copy_a: assert property (
    irq[0] && !START_DETECT_O[0] && c0.mode != MODE_ONE_COUNT
    |-> dat == $past(cnt)) else $error("bad capture");
  one_count_end_a: assert property (
    irq[0] && c0.mode == MODE_ONE_COUNT |-> cnt == CNT_ONES
    && $past(cnt) == CNT_ZERO ##1 cnt == CNT_ONES) else $error("bad end");
  start_pulse_a: assert property (
    (START_DETECT_O & $past(START_DETECT_O)) == 4'h0)
    else $error("long start pulse");
  level_readback_a: assert property (
    OUTPUT_LEVEL_GROUP_O == TIMER_OUTPUT_PIN_O) else $error("readback");
  master_toggle_a: assert property (
    $past(irq[0] && c0.output_enable_bit && !c0.output_mode_select)
    |-> pin[0] != $past(pin[0])) else $error("no toggle");
  enabled_hold_a: assert property (
    $past(c0.output_enable_bit && !irq[0]) |-> $stable(pin[0]))
    else $error("output moved without interrupt");
  disabled_write_a: assert property (
    $past(!c0.output_enable_bit && !RESET_I) |-> pin[0] == ($past(
    OUTPUT_LEVEL_WR_I) ? $past(OUTPUT_LEVEL_WDATA_I[0]) : $past(pin[0])))
    else $error("disabled output wrong");
  slave_set_reset_a: assert property (
    $past(c1.output_enable_bit && c1.output_mode_select && irq != 2'h0)
    |-> pin[1] == $past(irq[0] ? !(irq[1] | c1.output_polarity_bit)
    : c1.output_polarity_bit)) else $error("set/reset wrong");
endmodule

bind tco_timer tco_timer_properties tco_timer_properties_i (
  .CLK_I(CLK_I), .RESET_I(RESET_I), .CFG_I(CFG_I),
  .CHANNEL_START_TRIGGER_I(CHANNEL_START_TRIGGER_I),
  .CHANNEL_STOP_I(CHANNEL_STOP_I), .OUTPUT_LEVEL_WR_I(OUTPUT_LEVEL_WR_I),
  .OUTPUT_LEVEL_WDATA_I(OUTPUT_LEVEL_WDATA_I),
  .CHANNEL_ENABLED_FLAG_O(CHANNEL_ENABLED_FLAG_O),
  .CHANNEL_INTERRUPT_O(CHANNEL_INTERRUPT_O),
  .START_DETECT_O(START_DETECT_O), .STATUS_O(STATUS_O),
  .TIMER_OUTPUT_PIN_O(TIMER_OUTPUT_PIN_O),
  .OUTPUT_LEVEL_GROUP_O(OUTPUT_LEVEL_GROUP_O));

// File: tb/testbench.sv
// self-checking bench for the four-channel timer
`timescale 1ns/100ps
module testbench;
  import tco_pkg::*;
  logic            clk = 1'b0, rst = 1'b1, owr = 1'b0, l0;
  logic [3:0]      lvl = 4'h0, start = 4'h0, stop = 4'h0, rwr = 4'h0;
  logic [3:0]      odata = 4'h0, pins, en, irq, sdet, tout, tgrp;
  logic [15:0]     rdata = 16'h0;
  logic [31:0]     seed = 32'h7474;  // fixed seed, repeatable run
  tco_cfg_t [3:0]  cfg = '0;
  tco_stat_t [3:0] st;
  int              n_fail = 0, n_tests = 0, p, w, c0, c3, k;

  // a tick every cycle keeps all expected counts exact
  tco_timer #(.COUNT_DIV(1)) tco_timer_i (.CLK_I(clk), .RESET_I(rst),
    .TIMER_INPUT_PIN_I(pins), .CFG_I(cfg), .CHANNEL_START_TRIGGER_I(start),
    .CHANNEL_STOP_I(stop), .RELOAD_WR_I(rwr), .RELOAD_WDATA_I(rdata),
    .OUTPUT_LEVEL_WR_I(owr), .OUTPUT_LEVEL_WDATA_I(odata),
    .CHANNEL_ENABLED_FLAG_O(en), .CHANNEL_INTERRUPT_O(irq),
    .START_DETECT_O(sdet), .STATUS_O(st), .TIMER_OUTPUT_PIN_O(tout),
    .OUTPUT_LEVEL_GROUP_O(tgrp));
  tco_signal_source tco_signal_source_i (.level_i(lvl), .pin_o(pins));

  always #5 clk = ~clk;

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // a span of n cycles measured from load zero reads n - 1
  function automatic logic [15:0] span(input int n);
    return 16'(n - 1);
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // bounded wait for channel 0 start pulse (0) or interrupt (1)
  task automatic wait_for(input int what, output int n);
    n = 0;
    do begin
      tick(1);
      n++;
    end while (!(what ? irq[0] : sdet[0]) && n < 100);
    if (n >= 100) n_fail++;
  endtask
  task automatic print_verdict;
    if (n_fail == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // watchdog far beyond the few hundred cycles the run needs
  initial begin
    tick(20000);
    n_fail++;
    print_verdict();
  end

  initial begin
    tick(4);
    rst <= 1'b0;
    seed = xs(seed);
    odata <= seed[3:0];
    owr <= 1'b1;
    tick(1);
    owr <= 1'b0;
    tick(1);
    chk(16'(tout), 16'(seed[3:0]));
    chk(16'(tgrp), 16'(seed[3:0]));
    cfg[0].output_enable_bit <= 1'b1;
    cfg[1].output_enable_bit <= 1'b1;
    odata <= ~seed[3:0];
    owr <= 1'b1;
    tick(1);
    owr <= 1'b0;
    tick(1);
    chk(16'(tout), 16'({~seed[3:2], seed[1:0]}));
    for (int i = 0; i < 2; i++) begin
      stop <= 4'hf;
      tick(1);
      stop <= 4'h0;
      // mode, polarity and enable written together in one cycle, then the start
      cfg[0] <= '{MODE_CAPTURE, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
      cfg[1] <= '{MODE_CAPTURE, 1'b0, 1'b0, 1'b1, 1'b1, i[0]};
      cfg[2] <= '{MODE_CAPTURE, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
      cfg[3] <= '{MODE_CAPTURE, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
      tick(1);
      l0 = tout[0];
      start <= 4'hf;
      tick(1);
      start <= 4'h0;
      wait_for(0, k);
      chk(st[0].channel_counter, CNT_ZERO);
      chk(16'(irq[0]), 16'h1);
      chk(16'(en), 16'hf);
      tick(1);
      chk(16'(tout[1:0]), 16'({~i[0], ~l0}));
      seed = xs(seed);
      p = 16 + int'(seed[4:0]);
      for (int r = 0; r < 3; r++) begin
        lvl <= 4'hf;
        c0 = 0;
        c3 = 0;
        for (int j = 1; j <= 12; j++) begin
          tick(1);
          if (irq[0] && c0 == 0) c0 = j;
          if (irq[3] && c3 == 0) c3 = j;
          if (j == 6) lvl <= 4'h0;
        end
        // the first capture after start is disregarded
        if (r > 0) chk(st[0].reload_capture_value, span(p));
        else chk(16'(c3 - c0), 16'h2);
        tick(p - 12);
      end
    end
    stop <= 4'hf;
    tick(1);
    stop <= 4'h0;
    seed = xs(seed);
    w = 2 + int'(seed[3:0]);
    rdata <= 16'(w);
    rwr <= 4'h1;
    cfg[0].mode <= MODE_ONE_COUNT;
    tick(1);
    rwr <= 4'h0;
    start <= 4'h1;
    tick(1);
    start <= 4'h0;
    lvl <= 4'hf;
    wait_for(0, k);
    chk(st[0].channel_counter, 16'(w));
    wait_for(1, k);
    chk(16'(k), span(w + 2));
    chk(st[0].channel_counter, CNT_ONES);
    lvl <= 4'h0;
    stop <= 4'h1;
    tick(1);
    stop <= 4'h0;
    cfg[0].mode <= MODE_CAP_ONE_COUNT;
    tick(6);
    start <= 4'h1;
    tick(1);
    start <= 4'h0;
    seed = xs(seed);
    w = 3 + int'(seed[4:0]);
    lvl <= 4'hf;
    tick(w);
    lvl <= 4'h0;
    wait_for(1, k);
    chk(st[0].reload_capture_value, span(w));
    print_verdict();
  end
endmodule
